//--- pkg/vbm_pkg.sv
// Purpose: shared constants and carrier types for the supply monitor logic
// Assumes: comparator outputs arrive synchronous to clk_sys
// Notes:   control bits are plain ports, no register bus
//
// Overview of operation
// - session-end flag goes 0 to 1 when supply drops below 0.5 volts
// - both session-end enables clear: comparator off, its flag reads 0
// - both session-valid enables clear: only interrupts stop, flag stays live
// - both supply-valid enables clear: comparator off, its flag reads 0
// - each comparator output is a readable status bit
// - after reset external select is off; reported valid uses comparator
// - external indicator input is treated as constant one
// - external decode: bypass no invert gives 1, invert gives 0, else comparator
// - pulldown connected exactly while discharge control bit is set
// - pullup connected exactly while charge control bit is set
package vbm_pkg;
  localparam int         NUM_CMP       = 3;
  localparam int         IDX_END       = 0;
  localparam int         IDX_SESS      = 1;
  localparam int         IDX_VALID     = 2;
  localparam logic [2:0] RST_STATUS    = 3'h0;
  localparam logic [2:0] RST_ENABLE    = 3'h0;
  localparam logic       EXT_INDICATOR = 1'h1;

  typedef struct packed {
    logic ext_indicator_select;
    logic indicator_bypass_select;
    logic indicator_invert;
  } vbm_ind_cfg_t;

  typedef struct packed {
    logic supply_valid_flag;
    logic session_valid_flag;
    logic session_end_flag;
  } vbm_status_t;
endpackage : vbm_pkg

//--- hw/vbm_monitor.sv
// Purpose: status, interrupt and source-select logic of the supply monitor
// Assumes: raw comparator levels synchronous to clk_sys
// Notes:   all outputs registered, one cycle behind the inputs; irq_pulse is two cycles behind cmp_raw
`timescale 1ns/1ps
`default_nettype none
module vbm_monitor (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic [2:0]            cmp_raw,
  input  wire logic [2:0]            rise_en,
  input  wire logic [2:0]            fall_en,
  input  wire vbm_pkg::vbm_ind_cfg_t ind_cfg,
  input  wire logic                  supply_pulldown_ctl,
  input  wire logic                  supply_pullup_ctl,
  output var  vbm_pkg::vbm_status_t  status,
  output logic [2:0]                 cmp_power_en,
  output logic                       irq_pulse,
  output logic                       link_supply_valid,
  output logic                       pulldown_connect,
  output logic                       pullup_connect
);
  logic [2:0] next_status;
  logic       next_link_valid;
  logic [2:0] prev;

  // session-valid comparator is powered down only in reset; others follow enables
  genvar g;
  generate
    for (g = 0; g < vbm_pkg::NUM_CMP; g++) begin : g_cmp
      if (g == vbm_pkg::IDX_SESS) begin : g_live
        assign next_status[g] = cmp_raw[g];
      end else begin : g_gated
        assign next_status[g] = cmp_raw[g] & (rise_en[g] | fall_en[g]);
      end
    end
  endgenerate

  // external indicator is constant one, so only invert/bypass matter
  always_comb begin
    if (!ind_cfg.ext_indicator_select)
      next_link_valid = next_status[vbm_pkg::IDX_VALID];
    else if (ind_cfg.indicator_invert)
      next_link_valid = ~vbm_pkg::EXT_INDICATOR & 1'h0;
    else if (ind_cfg.indicator_bypass_select)
      next_link_valid = vbm_pkg::EXT_INDICATOR;
    else
      next_link_valid = next_status[vbm_pkg::IDX_VALID];
  end

  // one process per register group; clk_en low leaves every one untouched
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status <= vbm_pkg::RST_STATUS;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev <= vbm_pkg::RST_STATUS;
    end else if (clk_en) begin
      prev <= status;
    end
  end

  // session-valid comparator stays powered so its state remains readable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmp_power_en <= vbm_pkg::RST_ENABLE;
    end else if (clk_en) begin
      cmp_power_en <= (rise_en | fall_en) | 3'h2;
    end
  end

  // edge seen between the registered status and its previous value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_pulse <= 1'h0;
    end else if (clk_en) begin
      irq_pulse <= |((status & ~prev & rise_en) |
                     (~status & prev & fall_en));
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_supply_valid <= 1'h0;
    end else if (clk_en) begin
      link_supply_valid <= next_link_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulldown_connect <= 1'h0;
    end else if (clk_en) begin
      pulldown_connect <= supply_pulldown_ctl;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pullup_connect <= 1'h0;
    end else if (clk_en) begin
      pullup_connect <= supply_pullup_ctl;
    end
  end

  // checks share one clock; reset quiets them all
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_end_off;
    clk_en && !rise_en[0] && !fall_en[0];
  endsequence

  sequence s_valid_off;
    clk_en && !rise_en[2] && !fall_en[2];
  endsequence

  sequence s_rise(int i);
    clk_en && status[i] && !prev[i] && rise_en[i];
  endsequence

  sequence s_fall(int i);
    clk_en && !status[i] && prev[i] && fall_en[i];
  endsequence

  sequence s_ext_on;
    clk_en && ind_cfg.ext_indicator_select;
  endsequence

  // comparator trips and its enable still holds one cycle later
  sequence s_end_trip;
    clk_en && !status[0] && cmp_raw[0] && rise_en[0]
    ##1 clk_en && rise_en[0];
  endsequence

  sequence s_sess_drop;
    clk_en && status[1] && !cmp_raw[1] && fall_en[1]
    ##1 clk_en && fall_en[1];
  endsequence

  property p_end_gated;
    s_end_off |=> !status.session_end_flag;
  endproperty
  a_end_gated: assert property (p_end_gated)
    else $error("session end flag set while disabled");

  property p_valid_gated;
    s_valid_off |=> !status.supply_valid_flag;
  endproperty
  a_valid_gated: assert property (p_valid_gated)
    else $error("supply valid flag set while disabled");

  property p_sess_live;
    clk_en |=> status.session_valid_flag == $past(cmp_raw[1]);
  endproperty
  a_sess_live: assert property (p_sess_live)
    else $error("session valid flag not live");

  property p_end_follow;
    clk_en && cmp_raw[0] && rise_en[0] |=> status.session_end_flag;
  endproperty
  a_end_follow: assert property (p_end_follow)
    else $error("session end flag missed");

  property p_status_cmp;
    clk_en && (rise_en[2] || fall_en[2])
    |=> status.supply_valid_flag == $past(cmp_raw[2]);
  endproperty
  a_status_cmp: assert property (p_status_cmp)
    else $error("supply valid status mismatch");

  property p_end_cmp;
    clk_en && (rise_en[0] || fall_en[0])
    |=> status.session_end_flag == $past(cmp_raw[0]);
  endproperty
  a_end_cmp: assert property (p_end_cmp)
    else $error("session end status mismatch");

  property p_valid_follow;
    clk_en && cmp_raw[2] && fall_en[2] |=> status.supply_valid_flag;
  endproperty
  a_valid_follow: assert property (p_valid_follow)
    else $error("supply valid flag missed");

  property p_src_default;
    clk_en && !ind_cfg.ext_indicator_select
    |=> link_supply_valid == status.supply_valid_flag;
  endproperty
  a_src_default: assert property (p_src_default)
    else $error("reported valid not from comparator");

  property p_src_fixed;
    s_ext_on |=> link_supply_valid ==
      ($past(ind_cfg.indicator_invert) ? 1'h0 :
       $past(ind_cfg.indicator_bypass_select) ? 1'h1 :
       status.supply_valid_flag);
  endproperty
  a_src_fixed: assert property (p_src_fixed)
    else $error("external decode wrong");

  property p_src_invert;
    clk_en && ind_cfg.ext_indicator_select && ind_cfg.indicator_invert
    |=> !link_supply_valid;
  endproperty
  a_src_invert: assert property (p_src_invert)
    else $error("inverted indicator not fixed low");

  property p_src_bypass;
    clk_en && ind_cfg.ext_indicator_select &&
    ind_cfg.indicator_bypass_select && !ind_cfg.indicator_invert
    |=> link_supply_valid;
  endproperty
  a_src_bypass: assert property (p_src_bypass)
    else $error("bypassed indicator not fixed high");

  property p_src_internal;
    clk_en && ind_cfg.ext_indicator_select &&
    !ind_cfg.indicator_bypass_select && !ind_cfg.indicator_invert
    |=> link_supply_valid == status.supply_valid_flag;
  endproperty
  a_src_internal: assert property (p_src_internal)
    else $error("plain external select not from comparator");

  property p_pulldown;
    clk_en |=> pulldown_connect == $past(supply_pulldown_ctl);
  endproperty
  a_pulldown_ctl: assert property (p_pulldown)
    else $error("pulldown control wrong");

  property p_pullup;
    clk_en |=> pullup_connect == $past(supply_pullup_ctl);
  endproperty
  a_pullup_ctl: assert property (p_pullup)
    else $error("pullup control wrong");

  property p_irq_rise;
    s_rise(1) |=> irq_pulse;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("rising interrupt missed");

  property p_irq_valid;
    s_rise(2) |=> irq_pulse;
  endproperty
  a_irq_valid: assert property (p_irq_valid)
    else $error("supply valid rising interrupt missed");

  property p_irq_fall;
    s_fall(1) |=> irq_pulse;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("falling interrupt missed");

  property p_irq_end;
    s_end_trip |=> irq_pulse;
  endproperty
  a_irq_end: assert property (p_irq_end)
    else $error("session end trip raised no interrupt");

  property p_irq_sess;
    s_sess_drop |=> irq_pulse;
  endproperty
  a_irq_sess: assert property (p_irq_sess)
    else $error("session valid drop raised no interrupt");

  property p_irq_quiet;
    clk_en && rise_en == 3'h0 && fall_en == 3'h0 |=> !irq_pulse;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt while all enables clear");

  property p_sess_power;
    clk_en |=> cmp_power_en[1];
  endproperty
  a_sess_power: assert property (p_sess_power)
    else $error("session valid comparator powered down");

  property p_gate_power;
    clk_en |=> cmp_power_en[0] == $past(rise_en[0] || fall_en[0]) &&
               cmp_power_en[2] == $past(rise_en[2] || fall_en[2]);
  endproperty
  a_gate_power: assert property (p_gate_power)
    else $error("comparator power does not follow enables");

  property p_freeze_status;
    !clk_en |=> $stable(status) && $stable(cmp_power_en);
  endproperty
  a_freeze_status: assert property (p_freeze_status)
    else $error("status moved while clock enable low");

  property p_freeze_irq;
    !clk_en |=> $stable(irq_pulse);
  endproperty
  a_freeze_irq: assert property (p_freeze_irq)
    else $error("interrupt moved while clock enable low");

  property p_freeze_out;
    !clk_en |=> $stable(link_supply_valid) &&
                $stable(pulldown_connect) && $stable(pullup_connect);
  endproperty
  a_freeze_out: assert property (p_freeze_out)
    else $error("outputs moved while clock enable low");
endmodule : vbm_monitor
`default_nettype wire

//--- verification/vbm_link_model.sv
// Purpose: link side model that watches the reported status
// Assumes: status is registered in the clk_sys domain
// Notes:   only presence detection is modelled, no ulpi framing
`timescale 1ns/1ps
`default_nettype none
module vbm_link_model (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire vbm_pkg::vbm_status_t status,
  output var  logic                 supply_present
);
  // session valid, not supply valid: its threshold may be too high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) supply_present <= 1'h0;
    else supply_present <= status.session_valid_flag;
  end
endmodule : vbm_link_model
`default_nettype wire

//--- verification/vbm_tb.sv
// Purpose: directed bench for the supply monitor logic
// Assumes: outputs settle one cycle after inputs, irq two cycles after
// Notes:   clk_en dropped once to check that status and both pull outputs freeze; link valid reads 0 frozen or not
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1, pd = 1'h0, pu = 1'h0;
  logic [2:0] cmp = 3'h0, re = 3'h0, fe = 3'h0, cm, ce;
  vbm_pkg::vbm_ind_cfg_t cfg = 3'h0;
  vbm_pkg::vbm_status_t st;
  logic irq, lv, pdc, puc, sp;
  int errors = 0, n_compared = 0;
  vbm_monitor dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .cmp_raw(cmp), .rise_en(re), .fall_en(fe), .ind_cfg(cfg),
    .supply_pulldown_ctl(pd), .supply_pullup_ctl(pu), .status(st),
    .cmp_power_en(ce), .irq_pulse(irq), .link_supply_valid(lv),
    .pulldown_connect(pdc), .pullup_connect(puc));
  vbm_link_model link (.clk_sys(clk_sys), .reset_n(reset_n), .status(st),
    .supply_present(sp));
  initial forever #2 clk_sys = ~clk_sys;
  task apply(input logic [2:0] c, e, input logic [2:0] g, input logic [1:0] p);
    @(posedge clk_sys);
    cmp <= c; re <= e; fe <= e; cfg <= g; {pd, pu} <= p;
    @(posedge clk_sys);
    #1;
  endtask : apply
  task end_sim;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    `CHK(st, 3'h0)
    reset_n <= 1'h1;
    apply(3'h7, 3'h7, 3'h0, 2'h0);
    `CHK(st, 3'h7)
    `CHK(lv, 1'h1)
    `CHK(ce, 3'h7)
    apply(3'h6, 3'h7, 3'h0, 2'h0);
    @(posedge clk_sys);
    #1;
    `CHK(irq, 1'h1)
    apply(3'h7, 3'h7, 3'h0, 2'h0);
    @(posedge clk_sys);
    #1;
    `CHK(irq, 1'h1)
    apply(3'h7, 3'h0, 3'h0, 2'h0);
    `CHK(st, 3'h2)
    `CHK(sp, 1'h1)
    `CHK(ce, 3'h2)
    apply(3'h5, 3'h0, 3'h0, 2'h0);
    `CHK(st, 3'h0)
    @(posedge clk_sys);
    #1;
    `CHK(irq, 1'h0)
    `CHK(sp, 1'h0)
    // decode of every select, bypass and invert combination
    for (int k = 0; k < 16; k++) begin
      apply({k[3], 2'h3}, 3'h7, k[2:0], k[1:0]);
      cm = k[2] ? (k[0] ? 3'h0 : (k[1] ? 3'h1 : {2'h0, k[3]})) : k[3];
      `CHK(lv, cm[0])
      `CHK({pdc, puc}, k[1:0])
    end
    // clock enable low must freeze status, link valid and both pull outputs
    @(posedge clk_sys);
    clk_en <= 1'h0;
    apply(3'h0, 3'h0, 3'h0, 2'h0);
    `CHK(st, 3'h7)
    `CHK({lv, pdc, puc}, 3'h3)
    @(posedge clk_sys);
    clk_en <= 1'h1;
    @(posedge clk_sys);
    #1;
    `CHK(st, 3'h0)
    `CHK(ce, 3'h2)
    end_sim;
  end
endmodule : testbench
`default_nettype wire
